//--- inc/slms_pkg.sv
// Purpose: Shared constants and types for the serial link mode select block.
// Assumes: Registers are 8 bits wide, one per aligned APB word at index * 4.
// Notes: Offsets below are register indexes, not byte addresses.
package slms_pkg;

    // APB geometry
    localparam int SLMS_ADDR_W = 12;
    localparam logic [7:0] SLMS_NO_DATA = 8'h00;

    // Register indexes; byte address is index times four
    localparam logic [7:0] SLMS_PORT_SELECT_IDX = 8'h1e;
    localparam logic [7:0] SLMS_RX_CAP_IDX = 8'h20;
    localparam logic [7:0] SLMS_BRIDGE_CONTROL_IDX = 8'h4f;
    localparam logic [7:0] SLMS_BRIDGE_CFG_IDX = 8'h54;
    localparam logic [7:0] SLMS_LINK_MODE_IDX = 8'h5b;
    localparam logic [7:0] SLMS_LINK_STATUS_IDX = 8'h60;

    // Values after reset
    localparam logic [7:0] SLMS_PORT_SELECT_RST = 8'h01;
    localparam logic [7:0] SLMS_RX_CAP_RST = 8'h00;
    localparam logic [7:0] SLMS_BRIDGE_CONTROL_RST = 8'h00;
    localparam logic [7:0] SLMS_BRIDGE_CFG_RST = 8'h00;
    localparam logic [7:0] SLMS_LINK_MODE_RST = 8'h20;

    // Port select codes and the forced capability code
    localparam logic [7:0] SLMS_PORT_SEL_P0 = 8'h01;
    localparam logic [7:0] SLMS_PORT_SEL_P1 = 8'h02;
    localparam logic [7:0] SLMS_CAP_FORCE_DUAL = 8'h8f;

    // Field positions
    localparam int SLMS_DISPLAY_ID_OFF_BIT = 0;
    localparam int SLMS_AUX_AUDIO_BIT = 1;
    localparam int SLMS_REMOTE_COPY_BIT = 5;
    localparam int SLMS_OUTSIDE_CTRL_BIT = 7;
    localparam int SLMS_CABLE_KIND_BIT = 7;
    localparam int SLMS_PLL_RATE_RST_BIT = 5;
    localparam int SLMS_STAT_OVERSPEED_BIT = 3;
    localparam int SLMS_STAT_LEGACY_OK_BIT = 4;
    localparam int SLMS_STAT_STRAP_DONE_BIT = 5;

    // Link mode selection codes in bits 2:0
    localparam logic [2:0] SLMS_SEL_FORCE_DUAL = 3'b011;
    localparam logic [2:0] SLMS_SEL_NO_DUAL = 3'b100;

    // Pixel clock limits in MHz
    localparam logic [7:0] SLMS_SINGLE_MAX_MHZ = 8'd105;
    localparam logic [7:0] SLMS_LEGACY_MAX_MHZ = 8'd85;
    localparam logic [7:0] SLMS_DUAL_MAX_MHZ = 8'd210;
    localparam logic [7:0] SLMS_DUAL_MIN_MHZ = 8'd106;

    // Strap level bit positions (level index 0..7 is level one..eight)
    localparam int SLMS_SEL1_OUTSIDE_POS = 2;
    localparam int SLMS_SEL1_CABLE_POS = 1;
    localparam int SLMS_SEL1_REMOTE_POS = 0;
    localparam int SLMS_SEL0_DISPLAY_POS = 1;
    localparam int SLMS_SEL0_AUX_POS = 0;

    typedef enum logic [2:0] {
        SLMS_IDLE,
        SLMS_SINGLE,
        SLMS_SECONDARY,
        SLMS_DUAL,
        SLMS_REPLICATE
    } slms_mode_type;

    typedef struct packed {
        slms_mode_type mode;
        logic port0_on;
        logic port1_on;
        logic back1_on;
        logic half_rate;
        logic [1:0] sessions;
    } slms_link_type;

    typedef struct packed {
        logic display_id_off;
        logic aux_audio;
        logic outside_ctrl;
        logic cable_cable_type_strap;
        logic remote_copy;
    } slms_strap_type;

    localparam slms_link_type SLMS_LINK_RST = '{SLMS_IDLE, 1'b0, 1'b0, 1'b0, 1'b0, 2'd0};

endpackage

//--- rtl/slms_mode_select.sv
// Purpose: Strap capture, link mode selection and link register file.
// Assumes: Strap levels arrive already quantised; receiver presence,
//          capability and pixel clock rate come from the link side.
// Notes: APB slave, zero wait states, pslverr on unmapped addresses.
//
// Contract
// R1: Second strap level one to eight gives outside, cable, remote bits, msb first.
// R2: Display-id strap to bridge_control bit 0, aux audio to configuration bit 1.
// R3: Outside controller strap to configuration bit 7, cable strap to mode bit 7.
// R4: Remote display-id copy strap to configuration bit 5, software writable.
// R5: Single link sends all video on one port, up to 105 MHz.
// R6: Older receivers are supported in single link only below 85 MHz.
// R7: Forced single link turns off the secondary transmitter and its back channel.
// R8: Dual link alternates pixels on two half-rate ports, input up to 210 MHz.
// R9: Dual link with protection keeps one session covering both ports.
// R10: Auto selects dual link for a dual-capable receiver and a fast enough clock.
// R11: Replicate sends identical video to two receivers with two sessions.
// R12: Auto uses capabilities and pixel clock; two single receivers give replicate.
// R13: Receiver only on the secondary port sends video there alone.
// R14: Writing 011 to mode bits 2:0 disables auto and forces dual link.
// R15: Writing 100 keeps auto but forbids dual link, forcing single.
// R16: Port select 0x02 steers port registers to port 1, 0x01 to port 0.
// R17: Capability 0x8F written for port 1 makes port 1 dual capable.
// R18: Mode bit 5 enables link PLL reset on rate change; zero suppresses it.
// R19: Host clears the PLL reset enable after power-up configuration.
// R20: Host should force single or dual rather than rely on auto.
// R21: Host forces port 1 capability then restores port 0 before forcing mode.
// R22: Decoded strap values are written into their registers at power-up.
// R23: Cable bit one means coaxial cabling, zero means twisted pair.
// R24: Straps are sampled once after reset release and ignored afterwards.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module slms_mode_select
    import slms_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [SLMS_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Quantised strap levels
    input wire logic [2:0] second_config_strap_in,
    input wire logic [1:0] first_config_strap_in,
    // Link side observations
    input wire logic [1:0] rx_present_in,
    input wire logic [1:0] rx_dual_capable_in,
    input wire logic [7:0] pixel_clock_mhz_in,
    input wire logic rate_change_in,
    // Results
    output slms_link_type link_out,
    output slms_strap_type strap_out,
    output logic pll_reset_out,
    output logic rate_overspeed_out,
    output logic legacy_ok_out
);

    // Reset release through two flops; first flop feeds only the second
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    logic rst_n;
    assign rst_n = rst_sync_q;

    // Register storage
    logic [7:0] port_select_q;
    logic [7:0] rx_cap_q [2];
    logic [7:0] bridge_control_q;
    logic [7:0] bridge_configuration_q;
    logic [7:0] link_mode_control_q;
    logic strap_done_q;
    slms_link_type link_q;
    slms_link_type link_d;
    logic pll_reset_q;

    // R1: level index bits, msb first
    logic strap_outside;
    logic strap_cable;
    logic strap_remote;
    logic strap_display;
    logic strap_aux;
    assign strap_outside = second_config_strap_in[SLMS_SEL1_OUTSIDE_POS];
    assign strap_cable = second_config_strap_in[SLMS_SEL1_CABLE_POS];
    assign strap_remote = second_config_strap_in[SLMS_SEL1_REMOTE_POS];
    assign strap_display = first_config_strap_in[SLMS_SEL0_DISPLAY_POS];
    assign strap_aux = first_config_strap_in[SLMS_SEL0_AUX_POS];

    // R24: capture only in the first cycle after release
    logic strap_load;
    assign strap_load = !strap_done_q;

    // APB decode; only aligned word accesses reach a register
    logic [7:0] reg_idx;
    logic aligned;
    logic access;
    logic wr_en;
    logic hit_port_sel;
    logic hit_rx_cap;
    logic hit_bctl;
    logic hit_bcfg;
    logic hit_mode;
    logic hit_status;
    logic mapped;
    assign reg_idx = paddr_in[9:2];
    assign aligned = (paddr_in[1:0] == 2'b00) && (paddr_in[SLMS_ADDR_W-1:10] == 2'b00);
    assign access = psel_in && penable_in;
    assign hit_port_sel = aligned && (reg_idx == SLMS_PORT_SELECT_IDX);
    assign hit_rx_cap = aligned && (reg_idx == SLMS_RX_CAP_IDX);
    assign hit_bctl = aligned && (reg_idx == SLMS_BRIDGE_CONTROL_IDX);
    assign hit_bcfg = aligned && (reg_idx == SLMS_BRIDGE_CFG_IDX);
    assign hit_mode = aligned && (reg_idx == SLMS_LINK_MODE_IDX);
    assign hit_status = aligned && (reg_idx == SLMS_LINK_STATUS_IDX);
    assign mapped = hit_port_sel | hit_rx_cap | hit_bctl | hit_bcfg | hit_mode | hit_status;
    // Low byte lane carries all register data
    assign wr_en = access && pwrite_in && pstrb_in[0] && mapped;

    // R16: port 1 chosen only by its own code, anything else stays on port 0
    logic port1_sel;
    assign port1_sel = (port_select_q == SLMS_PORT_SEL_P1);

    // Port select register
    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
            port_select_q <= SLMS_PORT_SELECT_RST;
        else if (wr_en && hit_port_sel)
            port_select_q <= pwdata_in[7:0];
    end

    // Per-port receiver capability copies, steered by port select
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++)
        begin : g_cap
            logic sel_this;
            assign sel_this = (gp == 1) ? port1_sel : !port1_sel;
            always_ff @(posedge clk_in or negedge rst_n)
            begin
                if (!rst_n)
                    rx_cap_q[gp] <= SLMS_RX_CAP_RST;
                // R16: write lands in the selected port only
                else if (wr_en && hit_rx_cap && sel_this)
                    rx_cap_q[gp] <= pwdata_in[7:0];
            end
        end
    endgenerate

    // Strap loaded registers; the one-time load outranks a bus write
    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_done_q <= 1'b0;
            bridge_control_q <= SLMS_BRIDGE_CONTROL_RST;
            bridge_configuration_q <= SLMS_BRIDGE_CFG_RST;
            link_mode_control_q <= SLMS_LINK_MODE_RST;
        end
        // R22: decoded straps written into their homes
        else if (strap_load)
        begin
            strap_done_q <= 1'b1;
            // R2: display id select into bridge control
            bridge_control_q[SLMS_DISPLAY_ID_OFF_BIT] <= strap_display;
            // R2: aux audio into configuration
            bridge_configuration_q[SLMS_AUX_AUDIO_BIT] <= strap_aux;
            // R3: outside controller and cable kind
            bridge_configuration_q[SLMS_OUTSIDE_CTRL_BIT] <= strap_outside;
            link_mode_control_q[SLMS_CABLE_KIND_BIT] <= strap_cable;
            // R4: remote display id copy
            bridge_configuration_q[SLMS_REMOTE_COPY_BIT] <= strap_remote;
        end
        else if (wr_en)
        begin
            // R2: software may overwrite the latched bits
            if (hit_bctl)
                bridge_control_q <= pwdata_in[7:0];
            if (hit_bcfg)
                bridge_configuration_q <= pwdata_in[7:0];
            // R14: mode selection code written here
            if (hit_mode)
                link_mode_control_q <= pwdata_in[7:0];
        end
    end

    // Capability per port: reported by receiver or forced by software
    logic [1:0] dual_cap;
    // R17: forced capability code makes the port dual capable
    assign dual_cap[0] = rx_dual_capable_in[0] || (rx_cap_q[0] == SLMS_CAP_FORCE_DUAL);
    assign dual_cap[1] = rx_dual_capable_in[1] || (rx_cap_q[1] == SLMS_CAP_FORCE_DUAL);

    // Mode selection controls
    logic [2:0] link_sel;
    logic force_dual;
    logic no_dual;
    logic rate_dual_ok;
    assign link_sel = link_mode_control_q[2:0];
    // R14: auto off, dual forced
    assign force_dual = (link_sel == SLMS_SEL_FORCE_DUAL);
    // R15: auto kept, dual forbidden
    assign no_dual = (link_sel == SLMS_SEL_NO_DUAL);
    // R10: minimum rate for automatic dual link
    assign rate_dual_ok = (pixel_clock_mhz_in >= SLMS_DUAL_MIN_MHZ);

    // Mode choice and port usage
    always_comb
    begin
        link_d = SLMS_LINK_RST;
        if (force_dual)
            link_d.mode = SLMS_DUAL;
        else
        begin
            // R12: capability and rate drive the auto choice
            case (rx_present_in)
                2'b01:
                    // R10: dual capable receiver with enough rate
                    if (dual_cap[0] && rate_dual_ok && !no_dual)
                        link_d.mode = SLMS_DUAL;
                    else
                        link_d.mode = SLMS_SINGLE;
                2'b10:
                    // R13: secondary alone; R7 keeps it off when forced single
                    link_d.mode = no_dual ? SLMS_IDLE : SLMS_SECONDARY;
                2'b11:
                    if (dual_cap[0] && rate_dual_ok && !no_dual)
                        link_d.mode = SLMS_DUAL;
                    // R12: two independent receivers give replicate
                    else if (!no_dual)
                        link_d.mode = SLMS_REPLICATE;
                    else
                        link_d.mode = SLMS_SINGLE;
                2'b00:
                    link_d.mode = SLMS_IDLE;
                default:
                    link_d.mode = SLMS_IDLE;
            endcase
        end
        case (link_d.mode)
            SLMS_SINGLE:
            begin
                // R5: whole stream on the primary port
                link_d.port0_on = 1'b1;
                // R7: forced single shuts secondary and its back channel
                link_d.back1_on = !no_dual && dual_cap[1];
                link_d.sessions = 2'd1;
            end
            SLMS_SECONDARY:
            begin
                link_d.port1_on = 1'b1;
                link_d.back1_on = 1'b1;
                link_d.sessions = 2'd1;
            end
            SLMS_DUAL:
            begin
                // R8: alternating pixels, each port at half rate
                link_d.port0_on = 1'b1;
                link_d.port1_on = 1'b1;
                link_d.back1_on = 1'b1;
                link_d.half_rate = 1'b1;
                // R9: one session spans both ports
                link_d.sessions = 2'd1;
            end
            SLMS_REPLICATE:
            begin
                // R11: same video both ports, independent sessions
                link_d.port0_on = 1'b1;
                link_d.port1_on = 1'b1;
                link_d.back1_on = 1'b1;
                link_d.sessions = 2'd2;
            end
            SLMS_IDLE:
                link_d.sessions = 2'd0;
            default:
                link_d = SLMS_LINK_RST;
        endcase
    end

    // Rate checks against the active mode
    logic overspeed;
    logic legacy_ok;
    // R5: single and replicate carry at most 105 MHz; R8: dual at most 210 MHz
    assign overspeed = (link_q.mode == SLMS_DUAL) ? (pixel_clock_mhz_in > SLMS_DUAL_MAX_MHZ)
                                                  : (pixel_clock_mhz_in > SLMS_SINGLE_MAX_MHZ);
    // R6: older receivers only below 85 MHz in single link
    assign legacy_ok = (link_q.mode == SLMS_SINGLE) && (pixel_clock_mhz_in < SLMS_LEGACY_MAX_MHZ);

    // Registered link state and PLL reset pulse; held idle until straps land
    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_q <= SLMS_LINK_RST;
            pll_reset_q <= 1'b0;
        end
        else
        begin
            link_q <= strap_done_q ? link_d : SLMS_LINK_RST;
            // R18: reset PLL on rate change only while enabled
            pll_reset_q <= rate_change_in && link_mode_control_q[SLMS_PLL_RATE_RST_BIT];
        end
    end

    // Status word: mode, overspeed, legacy, strap done
    logic [7:0] status_word;
    assign status_word = {2'b00, strap_done_q, legacy_ok, overspeed, link_q.mode};

    // Read data mux; unmapped reads return zero
    logic [7:0] rd_byte;
    assign rd_byte = hit_port_sel ? port_select_q :
                     hit_rx_cap ? rx_cap_q[port1_sel] :
                     hit_bctl ? bridge_control_q :
                     hit_bcfg ? bridge_configuration_q :
                     hit_mode ? link_mode_control_q :
                     hit_status ? status_word : SLMS_NO_DATA;

    // Zero wait state slave; error only for unmapped addresses
    assign pready_out = 1'b1;
    assign pslverr_out = access && !mapped;
    assign prdata_out = {24'h000000, rd_byte};

    // R23: cable bit one selects cable_type_strap, zero twisted pair
    assign strap_out.cable_cable_type_strap = link_mode_control_q[SLMS_CABLE_KIND_BIT];
    assign strap_out.display_id_off = bridge_control_q[SLMS_DISPLAY_ID_OFF_BIT];
    assign strap_out.aux_audio = bridge_configuration_q[SLMS_AUX_AUDIO_BIT];
    assign strap_out.outside_ctrl = bridge_configuration_q[SLMS_OUTSIDE_CTRL_BIT];
    assign strap_out.remote_copy = bridge_configuration_q[SLMS_REMOTE_COPY_BIT];

    // Link state and PLL reset straight from flops; rate flags decoded from link_q and pixel clock
    assign link_out = link_q;
    assign pll_reset_out = pll_reset_q;
    assign rate_overspeed_out = overspeed;
    assign legacy_ok_out = legacy_ok;

endmodule

//--- test/slms_mode_select_monitor.sv
// Purpose: Port-level checks for the link mode select block.
// Assumes: Sees only the top ports; the mode register is shadowed from APB writes.
// Notes: Shadow resets like the real register so pll checks hold from reset.
`timescale 1ns/1ns
module slms_mode_select_checker
    import slms_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [SLMS_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [7:0] pixel_clock_mhz_in,
    input wire logic rate_change_in,
    input wire slms_link_type link_out,
    input wire logic pll_reset_out,
    input wire logic legacy_ok_out
);
    logic [7:0] mode_q;
    logic mode_wr;

    // Completed write to the mode register
    assign mode_wr = psel_in && penable_in && pwrite_in && pstrb_in[0] && (paddr_in == 12'h16c);

    // Shadow of the mode register, only bit 5 and bits 2:0 matter here
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            mode_q <= SLMS_LINK_MODE_RST;
        end
        else if (mode_wr)
        begin
            mode_q <= pwdata_in[7:0];
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    // Code held two cycles covers the one-cycle link latency
    sequence s_dual_held;
        (mode_q[2:0] == SLMS_SEL_FORCE_DUAL) [*2];
    endsequence
    sequence s_nodual_held;
        (mode_q[2:0] == SLMS_SEL_NO_DUAL) [*2];
    endsequence

    a_pll_follows: assert property (
        rate_change_in && mode_q[SLMS_PLL_RATE_RST_BIT] |=> pll_reset_out)
        else $error("pll reset missing after rate change");
    a_pll_quiet: assert property (
        !(rate_change_in && mode_q[SLMS_PLL_RATE_RST_BIT]) |=> !pll_reset_out)
        else $error("pll reset without enabled rate change");
    a_legacy_limit: assert property (
        legacy_ok_out == (link_out.mode == SLMS_SINGLE && pixel_clock_mhz_in < 8'd85))
        else $error("legacy flag wrong");
    a_forced_dual: assert property (
        s_dual_held |-> link_out.mode == SLMS_DUAL)
        else $error("forced dual not applied");
    a_forced_single: assert property (
        s_nodual_held |-> link_out.mode != SLMS_DUAL && !link_out.port1_on && !link_out.back1_on)
        else $error("forced single leaves secondary on");
    a_dual_half_rate: assert property (
        link_out.mode == SLMS_DUAL |-> link_out.port0_on && link_out.port1_on && link_out.half_rate)
        else $error("dual link ports wrong");
    a_dual_one_session: assert property (
        link_out.mode == SLMS_DUAL |-> link_out.sessions == 2'd1)
        else $error("dual link session count wrong");
    a_replicate_two: assert property (
        link_out.mode == SLMS_REPLICATE |-> link_out.sessions == 2'd2 && link_out.port0_on
            && link_out.port1_on && !link_out.half_rate)
        else $error("replicate outputs wrong");
    a_secondary_alone: assert property (
        link_out.mode == SLMS_SECONDARY |-> link_out.port1_on && !link_out.port0_on)
        else $error("secondary only mode wrong");
endmodule

bind slms_mode_select slms_mode_select_checker i_checker (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .pixel_clock_mhz_in(pixel_clock_mhz_in),
    .rate_change_in(rate_change_in), .link_out(link_out), .pll_reset_out(pll_reset_out),
    .legacy_ok_out(legacy_ok_out));

//--- test/slms_rx_model.sv
// Purpose: Downstream receivers as seen by the mode selector.
// Assumes: A receiver is reported only after its link has locked.
// Notes: Any change of attachment drops both links while they relock.
`timescale 1ns/1ns
module slms_rx_model
#(
    parameter int LOCK_CYCLES = 3
)
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [1:0] attach_in,
    input wire logic [1:0] dual_in,
    output logic [1:0] rx_present_out,
    output logic [1:0] rx_dual_capable_out
);
    int lock_cnt;
    logic [1:0] seen_q;

    // Relock after every cable change, so detection never sees a glitch-free swap
    always @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            seen_q <= 2'h0;
            lock_cnt <= 0;
            rx_present_out <= 2'h0;
        end
        else if (attach_in != seen_q)
        begin
            seen_q <= attach_in;
            lock_cnt <= 0;
            rx_present_out <= 2'h0;
        end
        else if (lock_cnt < LOCK_CYCLES)
            lock_cnt <= lock_cnt + 1;
        else
            rx_present_out <= seen_q;
    end

    // Only a locked receiver answers the capability query
    assign rx_dual_capable_out = rx_present_out & dual_in;
endmodule

//--- test/serial_link_mode_select_tb_top.sv
// Purpose: Directed bench for strap capture, registers and link mode choice.
// Assumes: APB answers with zero wait states; receivers lock in LOCK cycles.
// Notes: Every check compares against values worked out here.
`timescale 1ns/1ns
module serial_link_mode_select_tb_top
    import slms_pkg::*;
;
    localparam int LOCK = 3;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [3:0] pstrb_in = 4'h1;
    logic [2:0] second_in = 3'h0;
    logic [1:0] first_in = 2'h0;
    logic [7:0] pixel_in = 8'h00;
    logic rate_change_in = 1'b0;
    logic [1:0] attach = 2'h0;
    logic [1:0] dual = 2'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    slms_link_type link_out;
    slms_strap_type strap_out;
    logic pll_reset_out;
    logic overspeed_out;
    logic legacy_out;
    logic [1:0] rx_present;
    logic [1:0] rx_dual;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int checked = 0;
    // 50 MHz clock
    always #10 clk_in = ~clk_in;

    slms_mode_select i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .second_config_strap_in(second_in),
        .first_config_strap_in(first_in), .rx_present_in(rx_present),
        .rx_dual_capable_in(rx_dual), .pixel_clock_mhz_in(pixel_in),
        .rate_change_in(rate_change_in), .link_out(link_out), .strap_out(strap_out),
        .pll_reset_out(pll_reset_out), .rate_overspeed_out(overspeed_out),
        .legacy_ok_out(legacy_out));

    slms_rx_model #(.LOCK_CYCLES(LOCK)) i_rx (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .attach_in(attach), .dual_in(dual), .rx_present_out(rx_present),
        .rx_dual_capable_out(rx_dual));

    task automatic test_done;
    begin
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // Straps flip after capture, so a late sample would show up
    task automatic do_reset(input logic [2:0] s1, input logic [1:0] s0);
    begin
        arst_n_in <= 1'b0;
        second_in <= s1;
        first_in <= s0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        second_in <= ~s1;
        first_in <= ~s0;
        repeat (2) @(posedge clk_in);
    end
    endtask

    // One APB transfer; entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] q, output logic e);
    begin
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= {24'h0, d};
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1)
            @(posedge clk_in);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    begin
        apb(1'b0, a, 8'h00, rd, err);
        chk(rd, {24'h0, exp});
        chk({31'h0, err}, 32'h0);
    end
    endtask

    task automatic pulse_chk(input logic exp);
    begin
        rate_change_in <= 1'b1;
        @(posedge clk_in);
        rate_change_in <= 1'b0;
        #1 chk({31'h0, pll_reset_out}, {31'h0, exp});
        @(posedge clk_in);
        #1 chk({31'h0, pll_reset_out}, 32'h0);
        @(posedge clk_in);
    end
    endtask

    // Relock time plus one cycle of mode latency, with margin
    task automatic link_chk(input logic [1:0] at, input logic [1:0] dc, input logic [7:0] mhz,
        input slms_mode_type m, input logic over);
    begin
        attach <= at;
        dual <= dc;
        pixel_in <= mhz;
        repeat (LOCK + 6) @(posedge clk_in);
        chk({29'h0, link_out.mode}, {29'h0, m});
        chk({31'h0, overspeed_out}, {31'h0, over});
    end
    endtask

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        test_done();
    end

    initial
    begin
        for (int i = 0; i < 8; i++)
        begin
            do_reset(i[2:0], i[1:0]);
            chk({27'h0, strap_out}, {27'h0, i[1], i[0], i[2], i[1], i[0]});
        end
        do_reset(3'b101, 2'b10);
        rd_chk(12'h13c, 8'h01);
        rd_chk(12'h150, 8'ha0);
        rd_chk(12'h16c, 8'h20);
        rd_chk(12'h078, 8'h01);
        do_reset(3'b010, 2'b01);
        rd_chk(12'h150, 8'h02);
        rd_chk(12'h16c, 8'ha0);
        wr(12'h150, 8'ha0);
        rd_chk(12'h150, 8'ha0);
        wr(12'h13c, 8'h01);
        rd_chk(12'h13c, 8'h01);
        apb(1'b0, 12'h004, 8'h00, rd, err);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        pulse_chk(1'b1);
        wr(12'h16c, 8'h00);
        pulse_chk(1'b0);
        wr(12'h078, 8'h02);
        wr(12'h080, 8'h8f);
        wr(12'h078, 8'h01);
        rd_chk(12'h080, 8'h00);
        wr(12'h078, 8'h02);
        rd_chk(12'h080, 8'h8f);
        wr(12'h078, 8'h01);
        link_chk(2'b01, 2'b01, 8'd150, SLMS_DUAL, 1'b0);
        link_chk(2'b01, 2'b01, 8'd220, SLMS_DUAL, 1'b1);
        link_chk(2'b01, 2'b01, 8'd105, SLMS_SINGLE, 1'b0);
        link_chk(2'b01, 2'b00, 8'd120, SLMS_SINGLE, 1'b1);
        link_chk(2'b01, 2'b00, 8'd84, SLMS_SINGLE, 1'b0);
        link_chk(2'b01, 2'b00, 8'd85, SLMS_SINGLE, 1'b0);
        link_chk(2'b10, 2'b00, 8'd80, SLMS_SECONDARY, 1'b0);
        link_chk(2'b11, 2'b00, 8'd100, SLMS_REPLICATE, 1'b0);
        link_chk(2'b00, 2'b00, 8'd100, SLMS_IDLE, 1'b0);
        wr(12'h16c, 8'h03);
        link_chk(2'b01, 2'b00, 8'd50, SLMS_DUAL, 1'b0);
        wr(12'h16c, 8'h04);
        link_chk(2'b11, 2'b11, 8'd100, SLMS_SINGLE, 1'b0);
        rd_chk(12'h180, 8'h21);
        test_done();
    end
endmodule
